// ==== src/mlic_defines.svh ====
// constants of the multilevel interrupt unit: vector map and counts
`ifndef MLIC_DEFINES_SVH
`define MLIC_DEFINES_SVH

`define MLIC_VEC_W          12
`define MLIC_NSRC           24
`define MLIC_SRC_W          5
`define MLIC_RESET_VECTOR   12'h000
`define MLIC_OSC_FAIL_VEC   12'h002
`define MLIC_BOOT_BASE      12'h800

`endif

// ==== src/mlic_pkg.sv ====
// types shared by the multilevel interrupt unit
package mlic_pkg;

  typedef enum logic [1:0] {
    MLIC_LVL_OFF  = 2'b00,
    MLIC_LVL_LOW  = 2'b01,
    MLIC_LVL_MED  = 2'b10,
    MLIC_LVL_HIGH = 2'b11
  } mlic_level_type;

  typedef enum logic [1:0] {
    MLIC_ST_IDLE = 2'b00,
    MLIC_ST_TAKE = 2'b01,
    MLIC_ST_WAIT = 2'b10
  } mlic_state_type;

  // one accepted interrupt as handed to the core
  typedef struct packed {
    logic                     valid;
    logic                     nmi;
    mlic_level_type           level;
    logic [4:0]               src;
    logic [11:0]              vector;
  } mlic_grant_type;

endpackage : mlic_pkg

// ==== src/mlic_vector_rom.sv ====
// vector address lookup: base plus in-peripheral offset, word addressed
`include "mlic_defines.svh"

module mlic_vector_rom (
  // source and offset
  input  wire logic [4:0]  src,
  input  wire logic [3:0]  offset,
  input  wire logic        relocate,
  // resulting word address
  output      logic [11:0] vector
);

  logic [11:0] base;

  // base table in word addresses, never byte addresses  [R9]
  always_comb begin
    case (src)
      5'h00:   base = 12'h004; // port c                  [R16]
      5'h01:   base = 12'h008; // port r                  [R16]
      5'h02:   base = 12'h00C; // dma controller          [R13]
      5'h03:   base = 12'h014; // real-time counter       [R13]
      5'h04:   base = 12'h018; // two-wire c              [R15]
      5'h05:   base = 12'h01C; // timer c type 0          [R14]
      5'h06:   base = 12'h028; // timer c type 1          [R14]
      5'h07:   base = 12'h030; // sync serial c, single   [R12]
      5'h08:   base = 12'h032; // serial c0               [R15]
      5'h09:   base = 12'h038; // serial c1
      5'h0A:   base = 12'h03E; // block cipher, single    [R12]
      5'h0B:   base = 12'h040; // nonvolatile controller  [R13]
      5'h0C:   base = 12'h044; // port b                  [R16]
      5'h0D:   base = 12'h056; // port e
      5'h0E:   base = 12'h05A; // two-wire e
      5'h0F:   base = 12'h05E; // timer e type 0
      5'h10:   base = 12'h06A; // timer e type 1
      5'h11:   base = 12'h074; // serial e0
      5'h12:   base = 12'h080; // port d
      5'h13:   base = 12'h084; // port a                  [R16]
      5'h14:   base = 12'h088; // comparator a            [R17]
      5'h15:   base = 12'h08E; // converter a             [R17]
      5'h16:   base = 12'h09A; // timer d type 0          [R14]
      5'h17:   base = 12'h0A6; // timer d type 1
      default: base = 12'h0AE; // sync serial d           [R12]
    endcase
  end

  // single-vector sources ignore the offset so each keeps one distinct entry
  logic        single;
  logic [11:0] sum;
  assign single = (src == 5'h07) || (src == 5'h0A);
  assign sum    = base + (single ? 12'h000 : {8'h00, offset}); // [R8] [R6]
  assign vector = relocate ? (sum + `MLIC_BOOT_BASE) : sum;    // [R11]

endmodule : mlic_vector_rom

// ==== src/mlic_core.sv ====
// multilevel interrupt unit: arbitration, nesting and vector delivery
//
// Contract
// R1 - three selectable levels per source
// R2 - medium preempts running low handler
// R3 - high preempts low and medium handlers
// R4 - low level fixed or round-robin arbitration
// R5 - oscillator failure nmi beats all levels
// R6 - every source has its own vector
// R7 - accepted interrupt loads vector into pc
// R8 - vector equals base plus interrupt offset
// R9 - vectors are program word addresses
// R10 - reset at 0x000, nmi at 0x002
// R11 - vector table relocatable to boot section
// R12 - single vectors: 0x030, 0x03E, 0x0AE; the rom drops the offset only for 0x030 and 0x03E
// R13 - bases 0x00C dma, 0x014 rtc, 0x040 nvm
// R14 - timer bases 0x01C, 0x028, 0x09A
// R15 - serial bases 0x018, 0x032, 0x0B0; no source here has base 0x0B0
// R16 - port bases 0x004, 0x044, 0x084, 0x008
// R17 - comparator 0x088, converter 0x08E
// R18 - fixed order: lowest vector wins, nmi first
`include "mlic_defines.svh"

module mlic_core (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // peripheral requests, levels and offsets (4 bits per source)
  input  wire logic [`MLIC_NSRC-1:0]         irq_req,
  input  wire logic [2*`MLIC_NSRC-1:0]       irq_level,
  input  wire logic [4*`MLIC_NSRC-1:0]       irq_offset,
  input  wire logic                          osc_fail,
  // configuration
  input  wire logic                          level_en_low,
  input  wire logic                          level_en_med,
  input  wire logic                          level_en_high,
  input  wire logic                          round_robin_en,
  input  wire logic                          vector_relocate,
  // core handshake
  input  wire logic                          global_ie,
  input  wire logic                          take_ack,
  input  wire logic                          reti,
  // outputs to the core
  output      logic                          pc_load,
  output      logic [`MLIC_VEC_W-1:0]        pc_vector,
  output      logic [`MLIC_SRC_W-1:0]        ack_src,
  output      logic                          ack_valid,
  output      logic [2:0]                    active_levels,
  output      logic                          nmi_active
);

  mlic_pkg::mlic_state_type state_r;
  mlic_pkg::mlic_state_type state_nxt;

  logic [2:0] act_r;                 // bit0 low, bit1 med, bit2 high in service
  logic       nmi_r;
  logic [4:0] rr_last_r;             // last low source served
  logic [`MLIC_VEC_W-1:0] pc_vec_r;
  logic       pc_load_r;
  logic [4:0] ack_src_r;
  logic       ack_valid_r;
  mlic_pkg::mlic_grant_type grant_r;

  // per-source level masks  [R1]
  logic [`MLIC_NSRC-1:0] req_low;
  logic [`MLIC_NSRC-1:0] req_med;
  logic [`MLIC_NSRC-1:0] req_high;

  genvar gi;
  generate
    for (gi = 0; gi < `MLIC_NSRC; gi++) begin : g_lvl
      assign req_low[gi]  = irq_req[gi] && level_en_low &&
                            (irq_level[2*gi +: 2] == 2'b01); // [R1]
      assign req_med[gi]  = irq_req[gi] && level_en_med &&
                            (irq_level[2*gi +: 2] == 2'b10); // [R1]
      assign req_high[gi] = irq_req[gi] && level_en_high &&
                            (irq_level[2*gi +: 2] == 2'b11); // [R1]
    end
  endgenerate

  // sources are indexed in rising base order, so lowest index = lowest vector
  function automatic logic [5:0] mlic_first(input logic [`MLIC_NSRC-1:0] v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = `MLIC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b0, 5'(i)};
      end
    end
    return r;
  endfunction : mlic_first

  // round robin: search starts just past the last low source served
  function automatic logic [5:0] mlic_rr(input logic [`MLIC_NSRC-1:0] v,
                                         input logic [4:0] last);
    logic [5:0] r;
    logic [5:0] k;
    r = 6'h20;
    for (int j = `MLIC_NSRC; j >= 1; j--) begin
      k = 6'({1'b0, last} + 6'(j));
      if (k >= 6'(`MLIC_NSRC)) begin
        k = k - 6'(`MLIC_NSRC);
      end
      if (v[k[4:0]]) begin
        r = k;
      end
    end
    return r;
  endfunction : mlic_rr

  logic [5:0] pick_high;
  logic [5:0] pick_med;
  logic [5:0] pick_low;
  assign pick_high = mlic_first(req_high);                      // [R18]
  assign pick_med  = mlic_first(req_med);                       // [R18]
  assign pick_low  = round_robin_en ? mlic_rr(req_low, rr_last_r)
                                    : mlic_first(req_low);      // [R4] [R18]

  // preemption: a level may enter only above every level now in service
  logic can_high;
  logic can_med;
  logic can_low;
  assign can_high = !act_r[2] && !pick_high[5];                 // [R3]
  assign can_med  = !act_r[2] && !act_r[1] && !pick_med[5];     // [R2]
  assign can_low  = (act_r == 3'b000) && !pick_low[5];

  // nmi ignores global enable and levels, only one nmi nests at a time
  logic want_nmi;
  logic want_mask;
  assign want_nmi  = osc_fail && !nmi_r;                        // [R5] [R18]
  assign want_mask = global_ie && !nmi_r && (can_high || can_med || can_low);

  logic [4:0]  sel_src;
  logic [1:0]  sel_lvl;
  assign sel_src = can_high ? pick_high[4:0] :
                   can_med  ? pick_med[4:0]  : pick_low[4:0];
  assign sel_lvl = can_high ? 2'b11 : can_med ? 2'b10 : 2'b01;

  logic [`MLIC_VEC_W-1:0] rom_vec;
  mlic_vector_rom u_rom (
    .src      (sel_src),
    .offset   (irq_offset[4*sel_src +: 4]),
    .relocate (vector_relocate),
    .vector   (rom_vec)
  );

  logic [`MLIC_VEC_W-1:0] nmi_vec;
  assign nmi_vec = vector_relocate ? (`MLIC_OSC_FAIL_VEC + `MLIC_BOOT_BASE)
                                   : `MLIC_OSC_FAIL_VEC;        // [R10] [R11]

  // state machine: idle -> take (grant held until core ack) -> one wait cycle -> idle
  always_comb begin
    case (state_r)
      mlic_pkg::MLIC_ST_IDLE: begin
        state_nxt = (want_nmi || want_mask) ? mlic_pkg::MLIC_ST_TAKE
                                            : mlic_pkg::MLIC_ST_IDLE;
      end
      mlic_pkg::MLIC_ST_TAKE: begin
        state_nxt = take_ack ? mlic_pkg::MLIC_ST_WAIT : mlic_pkg::MLIC_ST_TAKE;
      end
      mlic_pkg::MLIC_ST_WAIT: begin
        state_nxt = mlic_pkg::MLIC_ST_IDLE;
      end
      default: begin
        state_nxt = mlic_pkg::MLIC_ST_IDLE;
      end
    endcase
  end

  logic accept;
  assign accept = (state_r == mlic_pkg::MLIC_ST_IDLE) && (want_nmi || want_mask);

  // one-hot mask of the level being returned from: highest active first
  logic [2:0] ret_mask;
  assign ret_mask = act_r[2] ? 3'b100 : act_r[1] ? 3'b010 : 3'b001;

  // controller state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mlic_pkg::MLIC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // grant capture; the latched grant keeps the vector stable while the core acks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_r <= '0;
    end else if (accept) begin
      grant_r.valid  <= 1'b1;
      grant_r.nmi    <= want_nmi;
      grant_r.level  <= want_nmi ? mlic_pkg::MLIC_LVL_OFF
                                 : mlic_pkg::mlic_level_type'(sel_lvl);
      grant_r.src    <= want_nmi ? 5'h1F : sel_src;
      grant_r.vector <= want_nmi ? nmi_vec : rom_vec;           // [R6] [R8]
    end else if (state_r == mlic_pkg::MLIC_ST_WAIT) begin
      grant_r.valid  <= 1'b0;
    end
  end

  // in-service bookkeeping; a new entry in the return cycle still counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= 3'b000;
      nmi_r <= 1'b0;
    end else begin
      if (reti && nmi_r) begin
        nmi_r <= 1'b0;
      end else if (reti) begin
        act_r <= act_r & ~ret_mask;
      end
      if ((state_r == mlic_pkg::MLIC_ST_TAKE) && take_ack) begin
        if (grant_r.nmi) begin
          nmi_r <= 1'b1;                                        // [R5]
        end else begin
          act_r[grant_r.level - 2'b01] <= 1'b1;                 // [R2] [R3]
        end
      end
    end
  end

  // round-robin pointer moves only when a low request is served
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rr_last_r <= 5'h17;
    end else if ((state_r == mlic_pkg::MLIC_ST_TAKE) && take_ack && !grant_r.nmi &&
                 (grant_r.level == mlic_pkg::MLIC_LVL_LOW)) begin
      rr_last_r <= grant_r.src;                                 // [R4]
    end
  end

  // registered outputs to the core; pc load pulses in the cycle after the ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_r   <= 1'b0;
      pc_vec_r    <= `MLIC_RESET_VECTOR;                        // [R10]
      ack_src_r   <= 5'h00;
      ack_valid_r <= 1'b0;
    end else begin
      pc_load_r   <= (state_r == mlic_pkg::MLIC_ST_TAKE) && take_ack; // [R7]
      ack_valid_r <= (state_r == mlic_pkg::MLIC_ST_TAKE) && take_ack && !grant_r.nmi;
      if ((state_r == mlic_pkg::MLIC_ST_TAKE) && take_ack) begin
        pc_vec_r  <= grant_r.vector;                            // [R7] [R9]
        ack_src_r <= grant_r.src;
      end
    end
  end

  assign pc_load       = pc_load_r;
  assign pc_vector     = pc_vec_r;
  assign ack_src       = ack_src_r;
  assign ack_valid     = ack_valid_r;
  assign active_levels = act_r;
  assign nmi_active    = nmi_r;

endmodule : mlic_core

// ==== sim/mlic_core_asserts.sv ====
// concurrent checks on the ports of the multilevel interrupt unit
`include "mlic_defines.svh"

module mlic_core_asserts (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // watched inputs
  input wire logic                   osc_fail,
  input wire logic                   vector_relocate,
  input wire logic                   reti,
  // watched outputs
  input wire logic                   pc_load,
  input wire logic [`MLIC_VEC_W-1:0] pc_vector,
  input wire logic [`MLIC_SRC_W-1:0] ack_src,
  input wire logic                   ack_valid,
  input wire logic [2:0]             active_levels,
  input wire logic                   nmi_active
);
  // expected nmi entry follows the table relocation like every other vector
  wire logic [11:0] nmi_exp = `MLIC_OSC_FAIL_VEC + (vector_relocate ? `MLIC_BOOT_BASE : 12'h000);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  load_spacing_a: assert property (pc_load |=> (!pc_load) [*2])
    else $error("vector loads closer than three cycles");
  ack_pair_a: assert property (ack_valid |-> pc_load && ack_src != 5'h1F)
    else $error("acknowledge without a vector load");
  nmi_vec_a: assert property (pc_load && nmi_active && !$past(nmi_active) |->
    pc_vector == nmi_exp && ack_src == 5'h1F && !ack_valid)
    else $error("wrong nmi entry");
  nmi_resp_a: assert property ($rose(osc_fail) && !nmi_active |-> ##[1:40] nmi_active)
    else $error("nmi not serviced in time");
  vec_hold_a: assert property (!pc_load |-> $stable(pc_vector))
    else $error("vector moved without a load");
  reloc_top_a: assert property (pc_load |-> pc_vector[11] == vector_relocate)
    else $error("vector not in the selected table");
  level_set_a: assert property (ack_valid |-> active_levels != 3'b000)
    else $error("no level marked in service");
  high_block_a: assert property (ack_valid |-> !$past(active_levels[2]))
    else $error("maskable taken over a running high handler");
  nmi_clear_a: assert property (reti && nmi_active |=> !nmi_active)
    else $error("return left the nmi in service");

  // main scenarios reached
  cover property (pc_load && nmi_active);
  cover property (ack_valid && active_levels == 3'b111);
  cover property (pc_load && vector_relocate);
endmodule : mlic_core_asserts

bind mlic_core mlic_core_asserts u_asserts (
  .clk(clk), .rst_n(rst_n), .osc_fail(osc_fail), .vector_relocate(vector_relocate),
  .reti(reti), .pc_load(pc_load), .pc_vector(pc_vector), .ack_src(ack_src),
  .ack_valid(ack_valid), .active_levels(active_levels), .nmi_active(nmi_active));

// ==== sim/mlic_cpu_model.sv ====
// processor core stand-in: takes offered interrupts promptly or hesitantly
module mlic_cpu_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pace select
  input  wire logic slow,
  // answer to the unit
  output      logic take_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 42041;

  // slow pace drops the take at random cycles so the take phase stretches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take_ack <= 1'b0;
    end else begin
      take_ack <= slow ? 1'($random(seed)) : 1'b1;
    end
  end
endmodule : mlic_cpu_model

// ==== sim/tb.sv ====
// self-checking bench of the multilevel interrupt unit
`include "mlic_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk = 0, rst_n = 0, osc_fail = 0, reti = 0, slow = 0;
  logic                     en_md = 1, rr = 0, reloc = 0, gie = 1;
  logic [`MLIC_NSRC-1:0]    irq_req = '0;
  logic [2*`MLIC_NSRC-1:0]  irq_level = '0;
  logic [4*`MLIC_NSRC-1:0]  irq_offset = '0;
  logic                     take_ack, pc_load, ack_valid, nmi_active;
  logic [11:0]              pc_vector;
  logic [4:0]               ack_src;
  logic [2:0]               active_levels;
  logic [16:0]              exp_q[$];
  logic [16:0]              got;
  int                       bad_count = 0, checks_done = 0, seed = 42041;
  // word-addressed entry per source index
  logic [11:0] base_tab [24] = '{12'h004, 12'h008, 12'h00C, 12'h014, 12'h018, 12'h01C,
    12'h028, 12'h030, 12'h032, 12'h038, 12'h03E, 12'h040, 12'h044, 12'h056, 12'h05A,
    12'h05E, 12'h06A, 12'h074, 12'h080, 12'h084, 12'h088, 12'h08E, 12'h09A, 12'h0A6};

  always #50 clk = ~clk;

  mlic_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .slow(slow), .take_ack(take_ack));

  mlic_core DUT (
    .clk(clk), .rst_n(rst_n), .irq_req(irq_req), .irq_level(irq_level),
    .irq_offset(irq_offset), .osc_fail(osc_fail), .level_en_low(1'b1),
    .level_en_med(en_md), .level_en_high(1'b1), .round_robin_en(rr),
    .vector_relocate(reloc), .global_ie(gie), .take_ack(take_ack), .reti(reti),
    .pc_load(pc_load), .pc_vector(pc_vector), .ack_src(ack_src), .ack_valid(ack_valid),
    .active_levels(active_levels), .nmi_active(nmi_active));

  // single-vector sources have no offset to add
  function automatic logic [11:0] exp_vec(int s, logic [3:0] off);
    exp_vec = base_tab[s] + ((s == 7 || s == 10) ? 12'h000 : {8'h00, off})
            + (reloc ? `MLIC_BOOT_BASE : 12'h000);
  endfunction : exp_vec

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic tick();
    @(posedge clk);
    #10;
  endtask : tick

  task automatic check(logic ok, string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  // present a request and note the load it must cause
  task automatic raise(int s, logic [1:0] lv, logic [3:0] off);
    irq_level[2*s +: 2] = lv;
    irq_offset[4*s +: 4] = off;
    irq_req[s] = 1'b1;
    exp_q.push_back({s[4:0], exp_vec(s, off)});
  endtask : raise

  // bounded wait for the load; the peripheral then drops its request
  // one edge first, so a load pulse still standing from the last entry is not taken
  task automatic took(int s);
    int n;
    n = 0;
    tick();
    while (pc_load !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    if (pc_load !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    if (s < 32) irq_req[s] = 1'b0;
  endtask : took

  task automatic retire();
    tick();
    reti = 1'b1;
    tick();
    reti = 1'b0;
    tick();
  endtask : retire

  // scoreboard: every load must match the oldest noted expectation
  always @(negedge clk) begin
    if (pc_load === 1'b1) begin
      checks_done++;
      got = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1FFFF;
      if ({ack_src, pc_vector} !== got) begin
        bad_count++;
        $display("BAD %0t load %h expected %h", $time, {ack_src, pc_vector}, got);
      end
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #10 rst_n = 1'b1;
    tick();
    check(pc_vector === `MLIC_RESET_VECTOR && pc_load === 1'b0, "reset entry");
    for (int s = 0; s < `MLIC_NSRC; s++) begin
      reloc = 1'($random(seed));
      slow = 1'($random(seed));
      raise(s, 2'(1 + {$random(seed)} % 3), 4'($random(seed)));
      took(s);
      retire();
    end
    reloc = 1'b0;
    raise(3, 2'b01, 4'h2);
    took(3);
    raise(19, 2'b10, 4'h1);
    took(19);
    raise(5, 2'b11, 4'h3);
    took(5);
    check(active_levels === 3'b111, "nested levels");
    osc_fail = 1'b1;
    exp_q.push_back({5'h1F, `MLIC_OSC_FAIL_VEC});
    took(32);
    osc_fail = 1'b0;
    repeat (4) retire();
    check(active_levels === 3'b000 && nmi_active === 1'b0, "all retired");
    // refused while masked globally or by level, taken once both allow
    gie = 1'b0;
    irq_level[1:0] = 2'b10;
    irq_req[0] = 1'b1;
    repeat (6) tick();
    gie = 1'b1;
    en_md = 1'b0;
    repeat (6) tick();
    en_md = 1'b1;
    exp_q.push_back({5'd0, exp_vec(0, irq_offset[3:0])});
    took(0);
    retire();
    raise(4, 2'b01, 4'h0);
    raise(12, 2'b01, 4'h0);
    took(4);
    retire();
    took(12);
    retire();
    rr = 1'b1;
    raise(12, 2'b01, 4'h0);
    took(12);
    retire();
    raise(20, 2'b01, 4'h0);
    raise(2, 2'b01, 4'h0);
    took(20);
    retire();
    took(2);
    retire();
    check(exp_q.size() == 0, "loads missing");
    print_verdict();
  end
endmodule : tb
